// ==== include/rpo_pkg.sv ====
// Purpose: Shared constants and types for the resolver position outputs.
// Assumes: Core logic on a 40 MHz ref_clk; serial link clocked by the host.
// Notes: All cycle counts derive from the link times, strobe width and step rate, and the clock rate.
package rpo_pkg;

	// ------------------------------------------------------------
	// Clock and widths
	// ------------------------------------------------------------
	localparam int RPO_CLK_KHZ = 40000;
	localparam int RPO_ANGLE_W = 12;
	localparam int RPO_BITCNT_W = 4;
	localparam logic [RPO_BITCNT_W-1:0] RPO_WORD_BITS = 4'hC;
	localparam int RPO_TMR_W = 5;
	localparam int RPO_SHIFT_W = 16;

	// ------------------------------------------------------------
	// Step strobe timing
	// ------------------------------------------------------------
	localparam int RPO_STROBE_NS = 300;
	localparam int RPO_STROBE_CYC = (RPO_STROBE_NS * RPO_CLK_KHZ) / 1000000;
	localparam int RPO_STEP_MAX_KHZ = 2048;
	localparam int RPO_STEP_GAP_CYC = (RPO_CLK_KHZ + RPO_STEP_MAX_KHZ - 1) / RPO_STEP_MAX_KHZ;
	localparam int RPO_STEP_CNT_W = 5;

	// ------------------------------------------------------------
	// Serial link timing (host side)
	// ------------------------------------------------------------
	localparam int RPO_SCLK_MAX_KHZ = 2000;
	localparam int RPO_SCLK_PER_CYC = (RPO_CLK_KHZ + RPO_SCLK_MAX_KHZ - 1) / RPO_SCLK_MAX_KHZ;
	localparam int RPO_SCLK_HALF_CYC = (RPO_SCLK_PER_CYC + 1) / 2;
	localparam int RPO_CS_SETUP_NS = 600;
	localparam int RPO_CS_SETUP_CYC = (RPO_CS_SETUP_NS * RPO_CLK_KHZ + 999999) / 1000000;
	localparam int RPO_CS_HOLD_NS = 100;
	localparam int RPO_CS_HOLD_CYC = (RPO_CS_HOLD_NS * RPO_CLK_KHZ + 999999) / 1000000;
	localparam int RPO_CS_GAP_NS = 250;
	localparam int RPO_CS_GAP_CYC = (RPO_CS_GAP_NS * RPO_CLK_KHZ + 999999) / 1000000;

	// ------------------------------------------------------------
	// Index pulse widths, in angle counts (one A cycle = four counts)
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RPO_IDX_QUARTER = 2'h0,
		RPO_IDX_HALF = 2'h1,
		RPO_IDX_FULL = 2'h2,
		RPO_IDX_SPARE = 2'h3
	} rpo_idx_e;
	localparam logic [RPO_ANGLE_W-1:0] RPO_IDX_CNT_QUARTER = 12'h001;
	localparam logic [RPO_ANGLE_W-1:0] RPO_IDX_CNT_HALF = 12'h002;
	localparam logic [RPO_ANGLE_W-1:0] RPO_IDX_CNT_FULL = 12'h004;
	localparam logic [RPO_ANGLE_W-1:0] RPO_ANGLE_MAX = 12'hFFF;

endpackage : rpo_pkg

// ==== include/rpo_if.sv ====
// Purpose: Three-wire serial position link between host and converter.
// Assumes: Data line idles high through a pull-up when nobody drives it.
// Notes: The wire level is resolved here from the device's output enable.
`timescale 1ns/100ps
interface rpo_if;
	logic cs_n;
	logic sclk;
	logic sdo;
	logic sdo_oe_n;
	logic data_line;

	assign data_line = sdo_oe_n ? 1'b1 : sdo;

	modport dev (
		input cs_n,
		input sclk,
		output sdo,
		output sdo_oe_n
	);

	modport host (
		output cs_n,
		output sclk,
		input data_line
	);
endinterface : rpo_if

// ==== design/rpo_dev.sv ====
// Purpose: Converter end: angle counter, encoder emulation, serial read port.
// Assumes: step_inc/step_dec come from tracking logic on ref_clk.
// Notes: The shift path runs on the host's serial clock.
`timescale 1ns/100ps
module rpo_dev
	import rpo_pkg::*;
#(
	parameter int ANGLE_W = RPO_ANGLE_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	rpo_if.dev link,
	// Tracking loop steps
	input wire logic step_inc,
	input wire logic step_dec,
	output logic step_ready,
	output logic step_strobe,
	// Width select pin, coded as rpo_idx_e
	input wire logic [1:0] index_width_select,
	// Encoder emulation
	output logic enc_a,
	output logic enc_b,
	output logic index_pulse,
	output logic rot_dir,
	output logic [ANGLE_W-1:0] angle
);

	// ------------------------------------------------------------
	// Core state on ref_clk
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ANGLE_W-1:0] angle;
		logic [ANGLE_W-1:0] snap;
		logic dir;
		logic a;
		logic b;
		logic idx;
		logic strobe;
		logic ready;
		logic [RPO_STEP_CNT_W-1:0] strobe_cnt;
		logic [RPO_STEP_CNT_W-1:0] gap_cnt;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic [1:0] ws_s1;
		logic [1:0] ws_s2;
		logic oe_n;
	} rpo_core_s;

	localparam logic [RPO_STEP_CNT_W-1:0] STROBE_LAST =
		RPO_STEP_CNT_W'(RPO_STROBE_CYC - 1);
	localparam logic [RPO_STEP_CNT_W-1:0] GAP_LAST =
		RPO_STEP_CNT_W'(RPO_STEP_GAP_CYC - 1);

	rpo_core_s core_q;
	rpo_core_s core_d;
	logic [ANGLE_W-1:0] next_angle;
	logic [ANGLE_W-1:0] idx_span;
	logic take_step;

	always_comb begin
		core_d = core_q;
		next_angle = core_q.angle;
		idx_span = RPO_IDX_CNT_QUARTER;
		take_step = core_q.ready && (step_inc ^ step_dec);

		// Two-flop synchronisers for the chip select and width pins.
		core_d.cs_s1 = link.cs_n;
		core_d.cs_s2 = core_q.cs_s1;
		core_d.cs_s3 = core_q.cs_s2;
		core_d.ws_s1 = index_width_select;
		core_d.ws_s2 = core_q.ws_s1;

		// Snapshot on the synchronised falling edge of chip select.
		if (core_q.cs_s3 && !core_q.cs_s2) begin
			core_d.snap = core_q.angle;
		end
		core_d.oe_n = core_q.cs_s2;

		// Strobe pulse and minimum step spacing.
		if (core_q.strobe) begin
			if (core_q.strobe_cnt == STROBE_LAST) begin
				core_d.strobe = 1'b0;
			end else begin
				core_d.strobe_cnt = core_q.strobe_cnt + 1'b1;
			end
		end
		if (!core_q.ready) begin
			if (core_q.gap_cnt == GAP_LAST) begin
				core_d.ready = 1'b1;
			end else begin
				core_d.gap_cnt = core_q.gap_cnt + 1'b1;
			end
		end

		if (take_step) begin
			if (step_inc) begin
				next_angle = core_q.angle + 1'b1;
			end else begin
				next_angle = core_q.angle - 1'b1;
			end
			core_d.angle = next_angle;
			core_d.dir = step_inc;
			core_d.strobe = 1'b1;
			core_d.strobe_cnt = '0;
			core_d.ready = 1'b0;
			core_d.gap_cnt = '0;
		end

		// Quadrature follows the two low counter bits as a Gray code.
		core_d.a = next_angle[1];
		core_d.b = next_angle[1] ^ next_angle[0];

		unique case (rpo_idx_e'(core_q.ws_s2))
			RPO_IDX_HALF: idx_span = RPO_IDX_CNT_HALF;
			RPO_IDX_FULL: idx_span = RPO_IDX_CNT_FULL;
			RPO_IDX_QUARTER,
			RPO_IDX_SPARE: idx_span = RPO_IDX_CNT_QUARTER;
		endcase
		core_d.idx = (next_angle < idx_span);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_q <= '{
				angle: '0,
				snap: '0,
				dir: 1'b1,
				a: 1'b0,
				b: 1'b0,
				idx: 1'b1,
				strobe: 1'b0,
				ready: 1'b1,
				strobe_cnt: '0,
				gap_cnt: '0,
				cs_s1: 1'b1,
				cs_s2: 1'b1,
				cs_s3: 1'b1,
				ws_s1: 2'h0,
				ws_s2: 2'h0,
				oe_n: 1'b1
			};
		end else begin
			core_q <= core_d;
		end
	end

	// ------------------------------------------------------------
	// Shift path on the serial clock
	// ------------------------------------------------------------
	// The snapshot is static from well before the first falling edge,
	// since the host waits out the setup time after chip select falls.
	typedef struct packed {
		logic [RPO_BITCNT_W-1:0] bitcnt;
		logic sdo;
	} rpo_shift_s;

	rpo_shift_s sh_q;
	rpo_shift_s sh_d;
	logic frame_rst;
	logic [RPO_BITCNT_W-1:0] bit_pos;

	// A high chip select holds the shift path at the start of a word.
	assign frame_rst = link.cs_n | ~rst_n;

	always_comb begin
		sh_d = sh_q;
		bit_pos = RPO_BITCNT_W'(ANGLE_W - 1) - sh_q.bitcnt;
		if (sh_q.bitcnt < RPO_WORD_BITS) begin
			sh_d.sdo = core_q.snap[bit_pos];
			sh_d.bitcnt = sh_q.bitcnt + 1'b1;
		end else begin
			sh_d.sdo = 1'b0;
		end
	end

	always_ff @(negedge link.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			sh_q <= '{bitcnt: '0, sdo: 1'b0};
		end else begin
			sh_q <= sh_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.sdo = sh_q.sdo;
	assign link.sdo_oe_n = core_q.oe_n;
	assign step_ready = core_q.ready;
	assign step_strobe = core_q.strobe;
	assign enc_a = core_q.a;
	assign enc_b = core_q.b;
	assign index_pulse = core_q.idx;
	assign rot_dir = core_q.dir;
	assign angle = core_q.angle;

endmodule : rpo_dev

// ==== design/rpo_host.sv ====
// Purpose: Host end: frames a serial read and collects the angle bits.
// Assumes: Serial clock is divided from ref_clk and idles high.
// Notes: Bits are sampled late in the high phase, after synchronising.
`timescale 1ns/100ps
module rpo_host
	import rpo_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	rpo_if.host link,
	// Read request
	input wire logic rd_req,
	input wire logic [RPO_BITCNT_W-1:0] rd_len,
	// Read answer
	output logic rd_busy,
	output logic rd_done,
	output logic [RPO_SHIFT_W-1:0] rd_data
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_LOW = 3'h3,
		H_HIGH = 3'h2,
		H_HOLD = 3'h6,
		H_GAP = 3'h4
	} rpo_hst_e;

	typedef struct packed {
		rpo_hst_e st;
		logic [RPO_TMR_W-1:0] tmr;
		logic [RPO_BITCNT_W:0] bits;
		logic [RPO_SHIFT_W-1:0] shreg;
		logic [RPO_SHIFT_W-1:0] data;
		logic cs_n;
		logic sclk;
		logic d_s1;
		logic d_s2;
		logic done;
		logic busy;
	} rpo_host_s;

	localparam logic [RPO_TMR_W-1:0] SETUP_LAST = RPO_TMR_W'(RPO_CS_SETUP_CYC - 1);
	localparam logic [RPO_TMR_W-1:0] HALF_LAST = RPO_TMR_W'(RPO_SCLK_HALF_CYC - 1);
	localparam logic [RPO_TMR_W-1:0] HOLD_LAST = RPO_TMR_W'(RPO_CS_HOLD_CYC - 1);
	localparam logic [RPO_TMR_W-1:0] GAP_LAST = RPO_TMR_W'(RPO_CS_GAP_CYC - 1);
	localparam logic [RPO_BITCNT_W:0] FULL_LEN = 5'h10;

	rpo_host_s q;
	rpo_host_s d;

	always_comb begin
		d = q;
		d.d_s1 = link.data_line;
		d.d_s2 = q.d_s1;
		d.done = 1'b0;
		if (q.tmr != '0) begin
			d.tmr = q.tmr - 1'b1;
		end
		unique case (q.st)
			H_IDLE: begin
				if (rd_req) begin
					d.st = H_SETUP;
					d.cs_n = 1'b0;
					d.busy = 1'b1;
					d.tmr = SETUP_LAST;
					d.shreg = '0;
					d.bits = (rd_len == '0) ? FULL_LEN : {1'b0, rd_len};
				end
			end
			H_SETUP: begin
				if (q.tmr == '0) begin
					d.st = H_LOW;
					d.sclk = 1'b0;
					d.tmr = HALF_LAST;
				end
			end
			H_LOW: begin
				if (q.tmr == '0) begin
					d.st = H_HIGH;
					d.sclk = 1'b1;
					d.tmr = HALF_LAST;
				end
			end
			H_HIGH: begin
				if (q.tmr == '0) begin
					d.shreg = {q.shreg[RPO_SHIFT_W-2:0], q.d_s2};
					d.bits = q.bits - 1'b1;
					if (q.bits == 5'h01) begin
						d.st = H_HOLD;
						d.tmr = HOLD_LAST;
					end else begin
						d.st = H_LOW;
						d.sclk = 1'b0;
						d.tmr = HALF_LAST;
					end
				end
			end
			H_HOLD: begin
				if (q.tmr == '0) begin
					d.st = H_GAP;
					d.cs_n = 1'b1;
					d.tmr = GAP_LAST;
					d.data = q.shreg;
					d.done = 1'b1;
				end
			end
			H_GAP: begin
				if (q.tmr == '0) begin
					d.st = H_IDLE;
					d.busy = 1'b0;
				end
			end
			default: begin
				d.st = H_IDLE;
				d.cs_n = 1'b1;
				d.sclk = 1'b1;
				d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{
				st: H_IDLE,
				tmr: '0,
				bits: '0,
				shreg: '0,
				data: '0,
				cs_n: 1'b1,
				sclk: 1'b1,
				d_s1: 1'b1,
				d_s2: 1'b1,
				done: 1'b0,
				busy: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.cs_n = q.cs_n;
	assign link.sclk = q.sclk;
	assign rd_busy = q.busy;
	assign rd_done = q.done;
	assign rd_data = q.data;

endmodule : rpo_host

// ==== sim/rpo_monitor.sv ====
// Purpose: Concurrent checks on the serial link and encoder outputs.
// Assumes: All sampling on ref_clk.
// Notes: Instantiated beside the link interface in the bench.
`timescale 1ns/100ps
module rpo_monitor
	import rpo_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe_n,
	// Device outputs
	input wire logic step_strobe,
	input wire logic step_ready,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic index_pulse,
	input wire logic rot_dir,
	input wire logic [RPO_ANGLE_W-1:0] angle
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Cycles since chip select last changed and since the last serial clock fall.
	int unsigned cs_edge_cyc;
	int unsigned fall_cyc;
	logic cs_p;
	logic sclk_p;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_p <= 1'b1;
			sclk_p <= 1'b1;
			cs_edge_cyc <= RPO_CS_GAP_CYC;
			fall_cyc <= RPO_SCLK_PER_CYC;
		end else begin
			cs_p <= cs_n;
			sclk_p <= sclk;
			cs_edge_cyc <= (cs_n != cs_p) ? 1 : cs_edge_cyc + 1;
			fall_cyc <= (sclk_p && !sclk) ? 1 : fall_cyc + 1;
		end
	end

	AST_OE_OFF: assert property (cs_n [*4] |-> sdo_oe_n)
		else $error("data line driven while deselected");
	AST_SDO_IDLE: assert property (cs_n |-> !sdo)
		else $error("shift path not cleared while deselected");
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:3] !sdo_oe_n)
		else $error("data line not enabled after select");
	AST_STROBE_LEN: assert property ($rose(step_strobe) |->
		step_strobe [*8] ##1 step_strobe [*4] ##1 !step_strobe)
		else $error("step strobe width wrong");
	AST_STEP_LSB: assert property ($rose(step_strobe) |->
		angle == $past(angle) + 12'h001 || angle == $past(angle) - 12'h001)
		else $error("angle moved by other than one count");
	AST_STROBE_PER_STEP: assert property ($changed(angle) |-> $rose(step_strobe))
		else $error("angle changed without strobe");
	AST_DIR: assert property ($rose(step_strobe) |->
		rot_dir == (angle == $past(angle) + 12'h001))
		else $error("sense output wrong");
	AST_GRAY: assert property ($changed(angle) |-> $changed(enc_a) != $changed(enc_b))
		else $error("not exactly one quadrature output toggled");
	AST_QUAD: assert property (enc_a == angle[1] && enc_b == (angle[1] ^ angle[0]))
		else $error("quadrature phase does not match angle");
	AST_STEP_GAP: assert property ($rose(step_strobe) |->
		!step_ready ##19 !step_ready ##1 step_ready)
		else $error("step spacing wrong");
	AST_INDEX_ZERO: assert property ((angle == '0) |-> index_pulse)
		else $error("index pulse missing at zero angle");
	AST_CS_SETUP: assert property ($fell(sclk) |-> !cs_n && cs_edge_cyc >= RPO_CS_SETUP_CYC)
		else $error("serial clock fell too soon after select");
	AST_SCLK_RATE: assert property ($fell(sclk) |-> fall_cyc >= RPO_SCLK_PER_CYC)
		else $error("serial clock faster than allowed");
	AST_CS_HOLD: assert property ($rose(cs_n) |-> fall_cyc >= RPO_CS_HOLD_CYC)
		else $error("select released too soon after last clock fall");
	AST_CS_GAP: assert property ($fell(cs_n) |-> cs_edge_cyc >= RPO_CS_GAP_CYC)
		else $error("select reasserted too soon");
endmodule : rpo_monitor

// ==== sim/resolver_position_outputs_bench.sv ====
// Purpose: Self-checking bench joining the host and device ends.
// Assumes: 40 MHz ref_clk; the host divides its own serial clock.
// Notes: Steps, index widths and reads of several lengths are exercised.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module resolver_position_outputs_bench
	import rpo_pkg::*;
;
	logic ref_clk;
	logic rst_n;
	logic step_inc;
	logic step_dec;
	logic step_ready;
	logic step_strobe;
	logic [1:0] index_width_select;
	logic enc_a;
	logic enc_b;
	logic index_pulse;
	logic rot_dir;
	logic [RPO_ANGLE_W-1:0] angle;
	logic rd_req;
	logic [RPO_BITCNT_W-1:0] rd_len;
	logic rd_busy;
	logic rd_done;
	logic [RPO_SHIFT_W-1:0] rd_data;
	logic [RPO_ANGLE_W-1:0] exp_ang;
	logic [RPO_ANGLE_W-1:0] span;
	logic exp_dir;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;

	rpo_if link_if ();
	rpo_dev rpo_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if), .step_inc(step_inc),
		.step_dec(step_dec), .step_ready(step_ready), .step_strobe(step_strobe),
		.index_width_select(index_width_select), .enc_a(enc_a), .enc_b(enc_b),
		.index_pulse(index_pulse), .rot_dir(rot_dir), .angle(angle));
	rpo_host rpo_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if), .rd_req(rd_req),
		.rd_len(rd_len), .rd_busy(rd_busy), .rd_done(rd_done), .rd_data(rd_data));
	rpo_monitor rpo_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .sdo(link_if.sdo), .sdo_oe_n(link_if.sdo_oe_n),
		.step_strobe(step_strobe), .step_ready(step_ready), .enc_a(enc_a), .enc_b(enc_b),
		.index_pulse(index_pulse), .rot_dir(rot_dir), .angle(angle));

	// ----
	// Closing and timeout
	// ----
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// ----
	// Access tasks
	// ----
	task automatic step(input logic inc, input logic dec);
		do @(negedge ref_clk); while (step_ready !== 1'b1);
		@(posedge ref_clk);
		step_inc <= inc;
		step_dec <= dec;
		@(posedge ref_clk);
		step_inc <= 1'b0;
		step_dec <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		if (inc != dec) begin
			exp_ang = inc ? exp_ang + 12'h001 : exp_ang - 12'h001;
			exp_dir = inc;
		end
		`CHK("angle", exp_ang, angle)
		`CHK("strobe", inc != dec, step_strobe)
		`CHK("enc_a", exp_ang[1], enc_a)
		`CHK("enc_b", exp_ang[1] ^ exp_ang[0], enc_b)
		`CHK("rot_dir", exp_dir, rot_dir)
		`CHK("index", exp_ang < span, index_pulse)
	endtask : step

	task automatic rd(input logic [3:0] len, input logic [15:0] e);
		do @(negedge ref_clk); while (rd_busy !== 1'b0);
		@(posedge ref_clk);
		rd_req <= 1'b1;
		rd_len <= len;
		@(posedge ref_clk);
		rd_req <= 1'b0;
		do @(negedge ref_clk); while (rd_done !== 1'b1);
		`CHK("rd_data", e, rd_data)
	endtask : rd

	// ----
	// Main sequence
	// ----
	initial begin
		rst_n = 1'b0;
		step_inc = 1'b0;
		step_dec = 1'b0;
		index_width_select = 2'h0;
		rd_req = 1'b0;
		rd_len = 4'hC;
		exp_ang = 12'h000;
		exp_dir = 1'b1;
		span = 12'h001;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		`CHK("index rst", 1'b1, index_pulse)
		`CHK("line idle", 1'b1, link_if.data_line)
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk);
			index_width_select <= s[1:0];
			span = (s == 1) ? 12'h002 : (s == 2) ? 12'h004 : 12'h001;
			repeat (4) @(posedge ref_clk);
			repeat (5) step(1'b1, 1'b0);
			repeat (5) step(1'b0, 1'b1);
		end
		step(1'b1, 1'b1);
		repeat (3) step(1'b0, 1'b1);
		rd(4'hC, {4'h0, exp_ang});
		rd(4'h0, {exp_ang, 4'h0});
		rd(4'h4, {12'h000, exp_ang[11:8]});
		repeat (8) step(1'b1, 1'b0);
		rd(4'hC, {4'h0, exp_ang});
		// The device releases the line a few cycles after select rises.
		repeat (4) @(negedge ref_clk);
		`CHK("line idle", 1'b1, link_if.data_line)
		wrap_up();
	end
endmodule : resolver_position_outputs_bench
